/* inc/sau_consts.vh */
/*
 Register offsets, field positions, reset values and timing counts for the
 two-channel serial unit (channel 0 transmits, channel 1 receives).
 Assumes an APB slave with 32-bit data; registers are 16 bits in low lanes.
*/
// Operation
// [R1] Direction field selects off, rx, tx, both
// [R2] Error interrupt enable gates reception error
// [R3] Parity field sets transmitted parity bit
// [R4] Receiver checks even or odd parity
// [R5] Parity 01: slot present, value unchecked
// [R6] Bit order: 0 MSB first, 1 LSB
// [R7] Stop field: none, one, two; 11 prohibited
// [R8] Length: 9, 7 or 8 bits
// [R9] Transfer clock is fmck over 2(N+1)
// [R10] Clock select picks prescaler output zero/one
// [R11] Source bit picks divider or external clock
// [R12] Receive starts by software or line edge
// [R13] Inversion bit picks falling or rising start
// [R14] Mode field: CSI, UART, I2C; 11 prohibited
// [R15] Interrupt at transfer end or buffer empty; the receive channel ignores its ISS bit and always interrupts at transfer end
// [R16] Software waits four clocks before start trigger
// [R17] Unit clock runs only while enable set
// [R18] Idle level bit drives the transmit line
// [R19] Output enable gates the transmit line
// [R20] Frame: start, data, parity, stops; idle high
// [R21] Receiver samples each bit at its middle
`ifndef SAU_CONSTS_VH
`define SAU_CONSTS_VH
`define SAU_OFF_TX_MODE 12'h000
`define SAU_OFF_TX_COMM 12'h004
`define SAU_OFF_TX_DATA 12'h008
`define SAU_OFF_RX_MODE 12'h00c
`define SAU_OFF_RX_COMM 12'h010
`define SAU_OFF_RX_DATA 12'h014
`define SAU_OFF_CTRL 12'h018
`define SAU_OFF_STATUS 12'h01c
`define SAU_RST_TX_MODE 16'h0022
`define SAU_RST_RX_MODE 16'h0022
`define SAU_RST_COMM 16'h0087
`define SAU_RST_DATA 16'h0000
`define SAU_RST_CTRL 16'h0003
`define SAU_B_TXE 15
`define SAU_B_RXE 14
`define SAU_B_EOC 10
`define SAU_B_PTC 8
`define SAU_B_DIR 7
`define SAU_B_SLC 4
`define SAU_B_DLS 0
`define SAU_B_CKS 15
`define SAU_B_CCS 14
`define SAU_B_STS 8
`define SAU_B_SIS 6
`define SAU_B_MD 1
`define SAU_B_ISS 0
`define SAU_B_CLKEN 0
`define SAU_B_IDLE 1
`define SAU_B_OE 2
`define SAU_B_START 3
`define SAU_B_TXGO 4
`define SAU_B_DIVN 9
`define SAU_MODE_UART 2'h1
`define SAU_RX_ARM_CYCLES 3'h4
`endif

/* hw/sau_uart_pair.v */
/*
 Two-channel asynchronous serial unit: channel 0 transmits, channel 1 receives.
 Assumes an APB master on pclk, prescaler outputs as single-cycle pclk enables,
 and an external serial clock / receive line that are asynchronous to pclk.
*/
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
`include "sau_consts.vh"
module sau_uart_pair (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Prescaler ticks and external clock
  input wire prescaler_out_zero,
  input wire prescaler_out_one,
  input wire ext_serial_clock,
  // Serial lines
  input wire receive_line,
  output reg transmit_line,
  // Events
  output reg tx_channel_interrupt,
  output reg rx_channel_interrupt,
  output reg reception_error_interrupt,
  output reg [8:0] rx_data
);
  ////////////////////////////////////////////////////////////////////////////
  reg [15:0] tx_mode_q, tx_comm_q, tx_data_q, rx_mode_q, rx_comm_q, rx_data_q, ctrl_q;
  reg [2:0] arm_cnt_q;
  reg [1:0] rx_sync_q, xck_sync_q;
  reg rx_prev_q, xck_prev_q, start_pend_q;
  wire wr = psel & penable & pwrite;
  wire clk_en = ctrl_q[`SAU_B_CLKEN]; // R17
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  function [3:0] word_bits;
    input [1:0] dls;
    begin
      case (dls) // R8
        2'h1: word_bits = 4'd9;
        2'h2: word_bits = 4'd7;
        default: word_bits = 4'd8;
      endcase
    end
  endfunction

  // One-cycle tick per transfer-clock period
  function transfer_clock_tick;
    input [15:0] mode;
    input pz, po, xe;
    input [7:0] cnt;
    input [6:0] n;
    begin
      if (mode[`SAU_B_CCS])
        transfer_clock_tick = xe; // R11
      else
        transfer_clock_tick = (mode[`SAU_B_CKS] ? po : pz) && (cnt == {n, 1'b1}); // R10 R9
    end
  endfunction

  function par_bit;
    input [8:0] d;
    input [3:0] len;
    input [1:0] ptc;
    reg [8:0] m;
    begin
      m = (len == 4'd9) ? d : (len == 4'd8) ? {1'b0, d[7:0]} : {2'b00, d[6:0]};
      case (ptc) // R3
        2'h2: par_bit = ^m;
        2'h3: par_bit = ~(^m);
        default: par_bit = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_mode_q <= `SAU_RST_TX_MODE;
      tx_comm_q <= `SAU_RST_COMM;
      tx_data_q <= `SAU_RST_DATA;
      rx_mode_q <= `SAU_RST_RX_MODE;
      rx_comm_q <= `SAU_RST_COMM;
      rx_data_q <= `SAU_RST_DATA;
      ctrl_q <= `SAU_RST_CTRL;
    end else begin
      ctrl_q[`SAU_B_START] <= 1'b0;
      ctrl_q[`SAU_B_TXGO] <= 1'b0;
      if (wr) begin
        case (paddr)
          `SAU_OFF_TX_MODE: tx_mode_q <= pwdata[15:0];
          `SAU_OFF_TX_COMM: tx_comm_q <= pwdata[15:0];
          `SAU_OFF_TX_DATA: tx_data_q <= pwdata[15:0];
          `SAU_OFF_RX_MODE: rx_mode_q <= pwdata[15:0];
          `SAU_OFF_RX_COMM: rx_comm_q <= pwdata[15:0];
          `SAU_OFF_RX_DATA: rx_data_q <= pwdata[15:0];
          `SAU_OFF_CTRL: ctrl_q <= {11'h000, pwdata[4:0]};
          default: ;
        endcase
      end
    end
  end

  reg tx_busy_q, rx_busy_q, par_err_q, frm_err_q;
  always @* begin
    case (paddr)
      `SAU_OFF_TX_MODE: prdata = {16'h0000, tx_mode_q};
      `SAU_OFF_TX_COMM: prdata = {16'h0000, tx_comm_q};
      `SAU_OFF_TX_DATA: prdata = {16'h0000, tx_data_q};
      `SAU_OFF_RX_MODE: prdata = {16'h0000, rx_mode_q};
      `SAU_OFF_RX_COMM: prdata = {16'h0000, rx_comm_q};
      `SAU_OFF_RX_DATA: prdata = {16'h0000, rx_data_q[15:9], rx_data};
      `SAU_OFF_CTRL: prdata = {16'h0000, ctrl_q};
      `SAU_OFF_STATUS: prdata = {28'h0, frm_err_q, par_err_q, rx_busy_q, tx_busy_q};
      default: prdata = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage is read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync_q <= 2'b11;
      xck_sync_q <= 2'b00;
      rx_prev_q <= 1'b1;
      xck_prev_q <= 1'b0;
    end else begin
      rx_sync_q <= {rx_sync_q[0], receive_line};
      xck_sync_q <= {xck_sync_q[0], ext_serial_clock};
      rx_prev_q <= rx_sync_q[1];
      xck_prev_q <= xck_sync_q[1];
    end
  end
  wire xck_rise = xck_sync_q[1] & ~xck_prev_q;
  wire rx_lvl = rx_sync_q[1] ^ rx_mode_q[`SAU_B_SIS]; // R13
  wire rx_prev_lvl = rx_prev_q ^ rx_mode_q[`SAU_B_SIS];

  ////////////////////////////////////////////////////////////////////////////
  // Transmit channel
  localparam TX_IDLE = 3'b001, TX_SHIFT = 3'b010, TX_END = 3'b100;
  reg [2:0] tx_st_q;
  reg [7:0] tx_div_q;
  reg [12:0] tx_sr_q;
  reg [3:0] tx_left_q;
  wire tx_on = clk_en && tx_comm_q[`SAU_B_TXE] &&
               tx_mode_q[`SAU_B_MD+1:`SAU_B_MD] == `SAU_MODE_UART; // R1 R14
  wire tx_tick = transfer_clock_tick(tx_mode_q, prescaler_out_zero, prescaler_out_one, xck_rise, tx_div_q,
                           tx_data_q[15:`SAU_B_DIVN]);
  wire [3:0] tx_len = word_bits(tx_comm_q[1:0]);
  wire [1:0] tx_ptc = tx_comm_q[`SAU_B_PTC+1:`SAU_B_PTC];
  wire [1:0] tx_slc = tx_comm_q[`SAU_B_SLC+1:`SAU_B_SLC];
  reg [8:0] tx_word;
  reg [12:0] tx_frame;
  integer i, j;
  always @* begin
    tx_word = tx_data_q[8:0];
    if (!tx_comm_q[`SAU_B_DIR]) begin // R6
      for (i = 0; i < 9; i = i + 1)
        tx_word[i] = (i < tx_len) ? tx_data_q[tx_len - 1 - i] : 1'b0;
    end
    // Frame packed LSB out first: start, data, parity, stops (R20)
    tx_frame = {13'h1fff};
    tx_frame[0] = 1'b0;
    for (i = 0; i < 9; i = i + 1)
      if (i < tx_len)
        tx_frame[i + 1] = tx_word[i];
    if (tx_ptc != 2'h0)
      tx_frame[tx_len + 1] = par_bit(tx_data_q[8:0], tx_len, tx_ptc); // R3
  end
  wire [3:0] tx_total = 4'd1 + tx_len + {3'b000, tx_ptc != 2'h0} +
                        ((tx_slc == 2'h2) ? 4'd2 : {3'b000, tx_slc == 2'h1}); // R7

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= TX_IDLE;
      tx_div_q <= 8'h00;
      tx_sr_q <= 13'h1fff;
      tx_left_q <= 4'h0;
      tx_busy_q <= 1'b0;
      tx_channel_interrupt <= 1'b0;
      transmit_line <= 1'b1;
    end else begin
      tx_channel_interrupt <= 1'b0;
      if (tx_st_q == TX_IDLE || tx_tick || !clk_en)
        tx_div_q <= 8'h00;
      else if (tx_mode_q[`SAU_B_CKS] ? prescaler_out_one : prescaler_out_zero)
        tx_div_q <= tx_div_q + 8'h01;
      case (tx_st_q)
        TX_IDLE: begin
          if (ctrl_q[`SAU_B_TXGO] && tx_on) begin
            tx_sr_q <= tx_frame;
            tx_left_q <= tx_total;
            tx_busy_q <= 1'b1;
            tx_st_q <= TX_SHIFT;
            tx_channel_interrupt <= tx_mode_q[`SAU_B_ISS]; // R15
          end
        end
        TX_SHIFT: begin
          if (!tx_on)
            tx_st_q <= TX_END;
          else if (tx_tick) begin
            tx_sr_q <= {1'b1, tx_sr_q[12:1]};
            tx_left_q <= tx_left_q - 4'h1;
            if (tx_left_q == 4'h1)
              tx_st_q <= TX_END;
          end
        end
        TX_END: begin
          tx_busy_q <= 1'b0;
          tx_channel_interrupt <= ~tx_mode_q[`SAU_B_ISS]; // R15
          tx_st_q <= TX_IDLE;
        end
        default: tx_st_q <= TX_IDLE;
      endcase
      if (!ctrl_q[`SAU_B_OE])
        transmit_line <= ctrl_q[`SAU_B_IDLE]; // R19 R18
      else if (tx_st_q == TX_SHIFT)
        transmit_line <= tx_sr_q[0];
      else
        transmit_line <= ctrl_q[`SAU_B_IDLE]; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive channel
  localparam RX_IDLE = 3'b001, RX_WAIT = 3'b010, RX_SHIFT = 3'b100;
  reg [2:0] rx_st_q;
  reg [7:0] rx_div_q;
  reg [3:0] rx_idx_q;
  reg [8:0] rx_sr_q;
  reg rx_par_q;
  wire rx_on = clk_en && rx_comm_q[`SAU_B_RXE] &&
               rx_mode_q[`SAU_B_MD+1:`SAU_B_MD] == `SAU_MODE_UART; // R1 R14
  wire rx_tick = transfer_clock_tick(rx_mode_q, prescaler_out_zero, prescaler_out_one, xck_rise, rx_div_q,
                           rx_data_q[15:`SAU_B_DIVN]);
  wire [3:0] rx_len = word_bits(rx_comm_q[1:0]);
  wire [1:0] rx_ptc = rx_comm_q[`SAU_B_PTC+1:`SAU_B_PTC];
  wire [3:0] rx_last = rx_len + {3'b000, rx_ptc != 2'h0} + {3'b000, rx_comm_q[`SAU_B_SLC+1:`SAU_B_SLC] != 2'h0};
  wire start_edge = rx_prev_lvl & ~rx_lvl; // R13
  reg [8:0] rx_word;
  always @* begin
    rx_word = rx_sr_q;
    if (!rx_comm_q[`SAU_B_DIR]) begin // R6
      for (j = 0; j < 9; j = j + 1)
        rx_word[j] = (j < rx_len) ? rx_sr_q[rx_len - 1 - j] : 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= RX_IDLE;
      rx_div_q <= 8'h00;
      rx_idx_q <= 4'h0;
      rx_sr_q <= 9'h000;
      rx_par_q <= 1'b0;
      rx_busy_q <= 1'b0;
      par_err_q <= 1'b0;
      frm_err_q <= 1'b0;
      rx_data <= 9'h000;
      rx_channel_interrupt <= 1'b0;
      reception_error_interrupt <= 1'b0;
      arm_cnt_q <= 3'h0;
      start_pend_q <= 1'b0;
    end else begin
      rx_channel_interrupt <= 1'b0;
      reception_error_interrupt <= 1'b0;
      if (!rx_on)
        arm_cnt_q <= 3'h0;
      else if (arm_cnt_q != `SAU_RX_ARM_CYCLES)
        arm_cnt_q <= arm_cnt_q + 3'h1; // R16
      if (ctrl_q[`SAU_B_START] && rx_on && arm_cnt_q == `SAU_RX_ARM_CYCLES)
        start_pend_q <= 1'b1;
      // First tick half a bit after the start edge, then one per bit
      if (rx_st_q == RX_WAIT && start_edge)
        rx_div_q <= {1'b0, rx_data_q[15:`SAU_B_DIVN]} + 8'h01; // R21
      else if (rx_st_q != RX_SHIFT || rx_tick || !clk_en)
        rx_div_q <= 8'h00;
      else if (rx_mode_q[`SAU_B_CKS] ? prescaler_out_one : prescaler_out_zero)
        rx_div_q <= rx_div_q + 8'h01;
      case (rx_st_q)
        RX_IDLE: begin
          rx_busy_q <= 1'b0;
          if (rx_on && (start_pend_q || rx_mode_q[`SAU_B_STS])) // R12
            rx_st_q <= RX_WAIT;
        end
        RX_WAIT: begin
          if (!rx_on)
            rx_st_q <= RX_IDLE;
          else if (start_edge) begin // R13
            rx_st_q <= RX_SHIFT;
            rx_idx_q <= 4'h0;
            rx_busy_q <= 1'b1;
          end
        end
        RX_SHIFT: begin
          if (!rx_on)
            rx_st_q <= RX_IDLE;
          else if (rx_tick) begin // R21
            rx_idx_q <= rx_idx_q + 4'h1;
            if (rx_idx_q >= 4'h1 && rx_idx_q <= rx_len)
              rx_sr_q[rx_idx_q - 4'h1] <= rx_lvl;
            if (rx_idx_q == rx_len + 4'h1 && rx_ptc != 2'h0)
              rx_par_q <= rx_lvl; // R5
            if (rx_idx_q == rx_last) begin
              rx_st_q <= RX_WAIT;
              rx_busy_q <= 1'b0;
              rx_data <= rx_word;
              rx_channel_interrupt <= 1'b1;
              par_err_q <= rx_ptc[1] &&
                           (par_bit(rx_word, rx_len, rx_ptc) != rx_par_q); // R4 R5
              frm_err_q <= (rx_comm_q[`SAU_B_SLC+1:`SAU_B_SLC] != 2'h0) && !rx_lvl;
              reception_error_interrupt <= rx_comm_q[`SAU_B_EOC] &&
                ((rx_ptc[1] && (par_bit(rx_word, rx_len, rx_ptc) != rx_par_q)) ||
                 ((rx_comm_q[`SAU_B_SLC+1:`SAU_B_SLC] != 2'h0) && !rx_lvl)); // R2
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
      if (!rx_on)
        start_pend_q <= 1'b0;
    end
  end
endmodule

/* verif/sau_uart_pair_checker.sv */
/* Port checks for sau_uart_pair.
   Assumes the register map and reset values of sau_consts.vh. */
`timescale 1ns/10ps
`include "sau_consts.vh"
module sau_uart_pair_checker (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Line and events
  input wire transmit_line,
  input wire tx_channel_interrupt,
  input wire rx_channel_interrupt,
  input wire reception_error_interrupt,
  input wire [8:0] rx_data
);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  reg [15:0] comm_q;
  reg [15:0] rmode_q;
  reg [15:0] rcomm_q;
  reg [15:0] ctrl_q;
  // Shadows; only bits with a defined field are compared
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comm_q <= `SAU_RST_COMM;
      rmode_q <= `SAU_RST_RX_MODE;
      rcomm_q <= `SAU_RST_COMM;
      ctrl_q <= `SAU_RST_CTRL;
    end else if (acc && pwrite) begin
      if (paddr == `SAU_OFF_TX_COMM) comm_q <= pwdata[15:0];
      if (paddr == `SAU_OFF_RX_MODE) rmode_q <= pwdata[15:0];
      if (paddr == `SAU_OFF_RX_COMM) rcomm_q <= pwdata[15:0];
      if (paddr == `SAU_OFF_CTRL) ctrl_q <= pwdata[15:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait:
    assert property (acc |-> pready) else $error("pready low in access");
  a_no_slave_error:
    assert property (acc |-> !pslverr) else $error("pslverr raised in access");
  a_unmapped_zero:
    assert property (rd && paddr[11:5] != 7'h0 |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_comm_readback:
    assert property (rd && paddr == `SAU_OFF_TX_COMM |-> prdata[31:16] == 16'h0 && (prdata[15:0] & 16'hc7b3) == (comm_q & 16'hc7b3))
    else $error("tx comm readback wrong");
  a_mode_readback:
    assert property (rd && paddr == `SAU_OFF_RX_MODE |-> (prdata[15:0] & 16'hc147) == (rmode_q & 16'hc147))
    else $error("rx mode readback wrong");
  a_idle_level:
    assert property ($past(presetn) && !ctrl_q[`SAU_B_OE] && $stable(ctrl_q) |-> transmit_line == ctrl_q[`SAU_B_IDLE])
    else $error("idle level not driven");
  a_err_gated:
    assert property (reception_error_interrupt |-> rcomm_q[`SAU_B_EOC]) else $error("error irq while masked");
  a_err_pulse:
    assert property (reception_error_interrupt |=> !reception_error_interrupt) else $error("error irq not a pulse");
  a_rx_end_pulse:
    assert property (rx_channel_interrupt |=> !rx_channel_interrupt) else $error("rx irq not a pulse");
  a_tx_end_pulse:
    assert property (tx_channel_interrupt |=> !tx_channel_interrupt) else $error("tx irq not a pulse");
  a_rxdata_at_end:
    assert property ($changed(rx_data) |-> rx_channel_interrupt || $past(rx_channel_interrupt))
    else $error("rx data changed outside frame end");
endmodule
bind sau_uart_pair sau_uart_pair_checker u_sau_uart_pair_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .transmit_line(transmit_line), .tx_channel_interrupt(tx_channel_interrupt),
  .rx_channel_interrupt(rx_channel_interrupt), .reception_error_interrupt(reception_error_interrupt),
  .rx_data(rx_data));

/* verif/sau_remote_uart.sv */
/* Remote UART on the far side of both serial lines.
   Assumes a fixed bit time in clk cycles and lines idling high. */
`timescale 1ns/10ps
module sau_remote_uart #(
  parameter int BIT_CYC = 16
) (
  // Clock and lines
  input wire logic clk,
  input wire logic listen,
  input wire logic transmit_line,
  output logic receive_line,
  // Captured frame
  output logic [12:0] cap_bits,
  output logic [7:0] cap_cnt
);
  initial begin
    receive_line = 1'b1;
    cap_bits = 13'h1fff;
    cap_cnt = 8'h0;
  end
  // Longest frame is 13 slots; idle after it must read high
  always begin
    @(negedge transmit_line iff listen);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 13; i++) begin
      cap_bits[i] = transmit_line;
      if (i < 12) repeat (BIT_CYC) @(posedge clk);
    end
    cap_cnt++;
  end
  task automatic send(input logic [12:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      receive_line <= bits[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    receive_line <= 1'b1;
  endtask
endmodule

/* verif/sau_uart_pair_tb_top.sv */
/* Self-checking bench for sau_uart_pair with a remote UART partner.
   Assumes prescaler output zero ticks every cycle, output one every other. */
`timescale 1ns/10ps
`include "sau_consts.vh"
module sau_uart_pair_tb_top;
  logic pclk, presetn, psel, penable, pwrite, po, listen;
  logic [11:0] paddr;
  logic [31:0] pwdata, r;
  logic [12:0] f;
  wire [31:0] prdata;
  wire pready, rxl, txl, txi, rxi, erri;
  wire [8:0] rx_data;
  wire [12:0] cap_bits;
  wire [7:0] cap_cnt;
  int n_errors, n_compared, cyc, ntx, nrx, nerr, ptc, dir, dls, slc, eoc, flip, d, b, t;
  logic [11:0] ra [0:7] = '{`SAU_OFF_TX_MODE, `SAU_OFF_TX_COMM, `SAU_OFF_RX_MODE, `SAU_OFF_RX_COMM,
    `SAU_OFF_TX_DATA, `SAU_OFF_RX_DATA, `SAU_OFF_CTRL, 12'h020};
  logic [15:0] rv [0:7] = '{`SAU_RST_TX_MODE, `SAU_RST_COMM, `SAU_RST_RX_MODE, `SAU_RST_COMM,
    `SAU_RST_DATA, `SAU_RST_DATA, `SAU_RST_CTRL, 16'h0};
  int rp [0:6] = '{0, 1, 2, 2, 3, 3, 3};
  int re [0:6] = '{1, 1, 1, 1, 1, 0, 1};
  int rf [0:6] = '{0, 1, 0, 1, 1, 1, 0};
  sau_uart_pair u_sau_uart_pair (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .prescaler_out_zero(1'b1), .prescaler_out_one(po), .ext_serial_clock(1'b0), .receive_line(rxl),
    .transmit_line(txl), .tx_channel_interrupt(txi), .rx_channel_interrupt(rxi),
    .reception_error_interrupt(erri), .rx_data(rx_data));
  sau_remote_uart #(.BIT_CYC(16)) u_sau_remote_uart (.clk(pclk), .listen(listen), .transmit_line(txl),
    .receive_line(rxl), .cap_bits(cap_bits), .cap_cnt(cap_cnt));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task report_and_stop();
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Event counters and hang guard
  always @(posedge pclk) begin
    // Half-rate tick; N is set per clock select so the bit time stays 16 cycles
    po <= ~po;
    cyc++;
    if (txi === 1'b1) ntx++;
    if (rxi === 1'b1) nrx++;
    if (erri === 1'b1) nerr++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Idle cycle after each transfer so no signal is assigned twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Line slots from start bit; stop slots equal the high idle level
  function automatic logic [12:0] frame(input int dv, pt, dr, ln);
    int len, k, par;
    logic [12:0] fr;
    len = (ln == 1) ? 9 : (ln == 2) ? 7 : 8;
    fr = 13'h1fff;
    fr[0] = 1'b0;
    k = 1;
    par = 0;
    for (int i = 0; i < len; i++) begin
      fr[k] = dr ? dv[i] : dv[len - 1 - i];
      par ^= dv[i];
      k++;
    end
    if (pt != 0) fr[k] = (pt == 1) ? 1'b0 : (pt == 2) ? par[0] : !par[0];
    return fr;
  endfunction
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    po = 1'b0;
    listen = 1'b0;
    r = $urandom(93);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", r, {16'h0, rv[i]});
    end
    apb(1'b1, `SAU_OFF_CTRL, 32'h3);
    repeat (3) @(posedge pclk);
    chk("idle high", txl, 32'h1);
    apb(1'b1, `SAU_OFF_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk("idle low", txl, 32'h0);
    apb(1'b1, `SAU_OFF_CTRL, 32'h7);
    repeat (3) @(posedge pclk);
    listen = 1'b1;
    for (int i = 0; i < 8; i++) begin
      ptc = i & 3;
      dir = i >> 2;
      dls = 1 + i % 3;
      slc = 1 + (i & 1);
      d = $urandom & 32'h1ff;
      apb(1'b1, `SAU_OFF_TX_COMM, 32'h8000 | ptc << 8 | dir << 7 | slc << 4 | dls);
      apb(1'b0, `SAU_OFF_TX_COMM, 32'h0);
      apb(1'b1, `SAU_OFF_TX_MODE, {16'h0, dir != 0, 15'h0022});
      apb(1'b1, `SAU_OFF_TX_DATA, (dir != 0 ? 32'h0600 : 32'h0e00) | d);
      b = cap_cnt;
      t = ntx;
      apb(1'b1, `SAU_OFF_CTRL, 32'h17);
      while (cap_cnt == b) @(posedge pclk);
      repeat (60) @(posedge pclk);
      chk("tx frame", cap_bits, frame(d, ptc, dir, dls));
      chk("tx end irq", ntx - t, 32'h1);
    end
    apb(1'b1, `SAU_OFF_RX_MODE, 32'h0122);
    apb(1'b0, `SAU_OFF_RX_MODE, 32'h0);
    apb(1'b1, `SAU_OFF_RX_DATA, 32'h0e00);
    for (int i = 0; i < 7; i++) begin
      ptc = rp[i];
      eoc = re[i];
      flip = rf[i];
      d = $urandom & 32'hff;
      apb(1'b1, `SAU_OFF_RX_COMM, 32'h4013 | (i & 1) << 7 | eoc << 10 | ptc << 8);
      repeat (4) @(posedge pclk);
      apb(1'b1, `SAU_OFF_CTRL, 32'h0f);
      f = frame(d, ptc, i & 1, 3);
      if (flip != 0) f[9] = ~f[9];
      b = nrx;
      t = nerr;
      u_sau_remote_uart.send(f, ptc != 0 ? 11 : 10);
      while (nrx == b) @(posedge pclk);
      repeat (4) @(posedge pclk);
      chk("rx word", rx_data, d);
      chk("rx error", nerr - t, flip != 0 && ptc > 1 && eoc != 0);
    end
    report_and_stop();
  end
endmodule
